/* design/bsq_pkg.sv */
// Purpose: Shared types and constants of the bus cycle sequencer.
// Assumes: One 10 MHz clock; the bus clock runs at half that rate.
// Notes:   The shared numbers of the logic are named here once; SYNC_W is local to bsq_top.
package bsq_pkg;

  // Bus states; ST_TI is a one-state internal cycle of two clocks, ST_TX a release state
  typedef enum logic [2:0] {
    ST_T1  = 3'h0,
    ST_T2  = 3'h1,
    ST_TW  = 3'h2,
    ST_T3  = 3'h3,
    ST_TI  = 3'h4,
    ST_TX  = 3'h5,
    ST_RST = 3'h6
  } bsq_state_t;

  // Kinds of machine cycle that the core may ask for
  typedef enum logic [2:0] {
    K_FETCH = 3'h0,
    K_MRD   = 3'h1,
    K_MWR   = 3'h2,
    K_IORD  = 3'h3,
    K_IOWR  = 3'h4,
    K_INTOP = 3'h5
  } bsq_kind_t;

  // Clock
  localparam int SYS_CLK_HZ = 10_000_000;

  // Register offsets on the register port
  localparam logic [3:0] REG_WAIT_CTL = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h1;

  // Wait control layout and reset value (both wait fields all ones)
  localparam int         IO_FLD_LO    = 4;
  localparam int         MEM_FLD_LO   = 6;
  localparam logic [7:0] WAIT_CTL_RST = 8'hf0;
  localparam logic [1:0] WAIT_FLD_MAX = 2'h3;

  // Wait generator
  localparam logic [2:0] IO_WAIT_BASE = 3'h1;
  localparam logic [2:0] WAIT_NONE    = 3'h0;

  // Reset pin must stay low this many bus clocks
  localparam logic [2:0] RESET_MIN_CLK = 3'h6;

  // Address constants
  localparam logic [3:0]  IO_HI_ZERO   = 4'h0;
  localparam logic [19:0] RESTART_ADDR = 20'h00000;

  // Status register padding above the used bits
  localparam logic [1:0] STATUS_PAD = 2'h0;

  // True for cycles that use the I/O request strobe
  function automatic logic is_io(input bsq_kind_t k);
    return (k == K_IORD) || (k == K_IOWR);
  endfunction

  // True for cycles that drive write data
  function automatic logic is_wr(input bsq_kind_t k);
    return (k == K_MWR) || (k == K_IOWR);
  endfunction

endpackage

/* design/bsq_wait_gen.sv */
// Purpose: Programmable wait state counter of the bus cycle sequencer.
// Assumes: Loaded once per external cycle, decremented per inserted wait.
// Notes:   Pending stays high until the programmed waits are used up.
`timescale 1ns/1ps
module bsq_wait_gen (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Control
  input  wire logic              load,
  input  wire bsq_pkg::bsq_kind_t kind,
  input  wire logic              io_internal,
  input  wire logic [1:0]        io_field,
  input  wire logic [1:0]        mem_field,
  input  wire logic              dec,
  // Result
  output logic                   pending
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] load_val;
  logic       is_mem;

  // Memory cycles take the field as is, external I/O one more
  assign is_mem   = (kind == bsq_pkg::K_FETCH) || (kind == bsq_pkg::K_MRD) ||
                    (kind == bsq_pkg::K_MWR);
  assign load_val = bsq_pkg::is_io(kind) && !io_internal ?
                    {1'b0, io_field} + bsq_pkg::IO_WAIT_BASE :
                    is_mem ? {1'b0, mem_field} :
                    bsq_pkg::WAIT_NONE;
  assign cnt_d    = load ? load_val :
                    (dec && pending) ? cnt_q - 3'h1 : cnt_q;
  assign pending  = cnt_q != bsq_pkg::WAIT_NONE;

  // Counter register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= bsq_pkg::WAIT_NONE;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

/* design/bsq_top.sv */
// Purpose: Bus state sequencer: T1/T2/TW/T3 machine cycles, waits, reset
//          restart and hand-over of the bus to an alternate master.
// Assumes: SYS_CLK runs at the crystal rate; a half-rate enable forms the
//          bus clock, so each bus state spans two SYS_CLK cycles.
// Notes:   Pin inputs pass two flip-flops, so external edges are seen late.
// Summary of operation
// - Memory/IO cycles T1-T3; internal cycles one T
// - Bus clock is oscillator divided by two
// - Wait states sit between T2 and T3
// - Opcode fetch strobe low during fetch cycles
// - Fetch drives translated address in T1
// - Fetch asserts memory request, read in T1
// - Fetch latches data entering T3, ends T3
// - Sample wait at falling edge, repeat waits
// - Address and strobes held during wait states
// - Data reads: no fetch strobe, late latch
// - Write strobe and data timing per cycle
// - IO: io request, 16-bit address, upper zero
// - External IO always gets one wait
// - Reset low six clocks restarts at zero
// - Bus request low, grant low after release
// - Release only at machine cycle boundary
// - Released bus floats address, data, strobes
// - No refresh while bus is released
// - Bus request sampled before T3, T1, TX
// - Wait is OR of pin and generator
// - Refresh suspended during wait states
// - Wait control fields: IO 5:4, memory 7:6
// - Memory waits equal the field value
// - External IO waits are field plus one
// - Waits are maximum of pin and generator
// - Reset sets fields to ones, aborts waits
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module bsq_top (
  // Clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               RST,
  // Bus clock out
  output logic                    BUS_CLK,
  // Register port
  input  wire logic [3:0]         REG_ADDR,
  input  wire logic [7:0]         REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output logic [7:0]              REG_RDATA,
  // Cycle requests from the core
  input  wire logic               REQ_VALID,
  input  wire bsq_pkg::bsq_kind_t REQ_KIND,
  input  wire logic [19:0]        REQ_ADDR,
  input  wire logic [7:0]         REQ_WDATA,
  input  wire logic               REQ_IO_INTERNAL,
  output logic                    REQ_READY,
  output logic                    RSP_VALID,
  output logic [7:0]              RSP_DATA,
  output logic                    RESTART,
  // Address and data pins
  output logic [19:0]             ADDR_OUT,
  output logic                    ADDR_OE,
  input  wire logic [7:0]         DATA_IN,
  output logic [7:0]              DATA_OUT,
  output logic                    DATA_OE,
  // Control pins
  output logic                    MEMORY_REQUEST_N,
  output logic                    IO_REQUEST_N,
  output logic                    READ_STROBE_N,
  output logic                    WRITE_STROBE_N,
  output logic                    CTL_OE,
  output logic                    OPCODE_FETCH_STROBE_N,
  input  wire logic               WAIT_N,
  input  wire logic               RESET_N,
  // Bus exchange and refresh
  input  wire logic               BUS_REQUEST_N,
  output logic                    BUS_GRANT_N,
  output logic                    REFRESH_HOLD
);

  // Synchroniser layout: data, wait, reset, bus request
  localparam int SYNC_W = 11;

  logic [SYNC_W-1:0]   sync1_q;
  logic [SYNC_W-1:0]   sync2_q;
  logic [7:0]          data_s;
  logic                wait_s;
  logic                reset_s;
  logic                breq_s;

  logic                ph_q;
  logic                tick;
  logic                bclk_q;

  bsq_pkg::bsq_state_t st_q;
  bsq_pkg::bsq_state_t st_n;
  bsq_pkg::bsq_kind_t  kind_q;
  bsq_pkg::bsq_kind_t  kind_n;
  logic [19:0]         addr_q;
  logic [19:0]         addr_n;
  logic [7:0]          wdata_q;
  logic [7:0]          wdata_n;
  logic                io_int_q;
  logic                io_int_n;

  logic [2:0]          rst_cnt_q;
  logic                pin_rst;
  logic                rst_exit;
  logic                bnd;
  logic                accept;
  logic                wait_smp_q;
  logic                breq_smp_q;
  logic                wait_comb;
  logic                gen_pend;
  logic                gen_dec;
  logic [7:0]          wait_ctl_q;
  logic [7:0]          reg_rdata_q;

  logic                ph_n;
  logic                act;
  logic                late;
  logic                strb;
  logic                mem_kind;
  logic                rd_kind;
  logic                capture;
  logic [7:0]          rsp_data_q;
  logic                rsp_valid_q;
  logic                restart_q;
  logic [19:0]         addr_out_q;
  logic                addr_oe_q;
  logic [7:0]          data_out_q;
  logic                data_oe_q;
  logic                memory_request_n_n_q;
  logic                io_request_n_n_q;
  logic                rd_n_q;
  logic                wr_n_q;
  logic                ctl_oe_q;
  logic                m1_n_q;
  logic                grant_n_q;
  logic                refr_hold_q;

  // Two-stage synchroniser for every pin input
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sync1_q <= {SYNC_W{1'b1}};
      sync2_q <= {SYNC_W{1'b1}};
    end else begin
      sync1_q <= {DATA_IN, WAIT_N, RESET_N, BUS_REQUEST_N};
      sync2_q <= sync1_q;
    end
  end

  assign data_s  = sync2_q[SYNC_W-1:3];
  assign wait_s  = sync2_q[2];
  assign reset_s = sync2_q[1];
  assign breq_s  = sync2_q[0];

  // Half-rate phase: 0 is the high half of a bus clock, 1 the low half
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ph_q   <= 1'b0;
      bclk_q <= 1'b1;
    end else begin
      ph_q   <= ~ph_q;
      bclk_q <= ph_q;
    end
  end

  // A state ends at the end of its low half
  assign tick = ph_q;
  assign ph_n = ~ph_q;

  // Reset pin qualifier counted in bus clocks
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rst_cnt_q <= 3'h0;
    end else if (reset_s) begin
      rst_cnt_q <= 3'h0;
    end else if (tick && !pin_rst) begin
      rst_cnt_q <= rst_cnt_q + 3'h1;
    end
  end

  assign pin_rst  = rst_cnt_q == bsq_pkg::RESET_MIN_CLK;
  assign rst_exit = tick && (st_q == bsq_pkg::ST_RST) && !pin_rst;

  // Falling-edge samples of combined wait and bus request
  assign wait_comb = (!wait_s && !pin_rst) || gen_pend;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wait_smp_q <= 1'b0;
      breq_smp_q <= 1'b0;
    end else if (!ph_q) begin
      wait_smp_q <= wait_comb;
      breq_smp_q <= !breq_s;
    end
  end

  // Boundaries: end of T3, of an internal cycle, or of a release state
  assign bnd = (st_q == bsq_pkg::ST_T3) || (st_q == bsq_pkg::ST_TI) ||
               (st_q == bsq_pkg::ST_TX);
  assign REQ_READY = tick && bnd && !breq_smp_q && !pin_rst;
  assign accept    = REQ_READY && REQ_VALID;

  // Next state
  always_comb begin
    st_n = st_q;
    if (pin_rst) begin
      st_n = bsq_pkg::ST_RST;
    end else if (tick) begin
      case (st_q)
        bsq_pkg::ST_T1: begin
          st_n = bsq_pkg::ST_T2;
        end
        bsq_pkg::ST_T2, bsq_pkg::ST_TW: begin
          st_n = wait_smp_q ? bsq_pkg::ST_TW : bsq_pkg::ST_T3;
        end
        bsq_pkg::ST_T3, bsq_pkg::ST_TI, bsq_pkg::ST_TX: begin
          if (breq_smp_q) begin
            st_n = bsq_pkg::ST_TX;
          end else if (REQ_VALID && REQ_KIND != bsq_pkg::K_INTOP) begin
            st_n = bsq_pkg::ST_T1;
          end else begin
            st_n = bsq_pkg::ST_TI;
          end
        end
        bsq_pkg::ST_RST: begin
          st_n = bsq_pkg::ST_T1;
        end
        default: begin
          st_n = bsq_pkg::ST_TI;
        end
      endcase
    end
  end

  // Cycle parameters taken at acceptance; restart fetches from zero
  assign kind_n   = rst_exit ? bsq_pkg::K_FETCH : accept ? REQ_KIND : kind_q;
  assign addr_n   = rst_exit ? bsq_pkg::RESTART_ADDR :
                    !accept ? addr_q :
                    bsq_pkg::is_io(REQ_KIND) ?
                    {bsq_pkg::IO_HI_ZERO, REQ_ADDR[15:0]} : REQ_ADDR;
  assign wdata_n  = accept ? REQ_WDATA : wdata_q;
  assign io_int_n = rst_exit ? 1'b0 : accept ? REQ_IO_INTERNAL : io_int_q;

  // State and cycle registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_q     <= bsq_pkg::ST_RST;
      kind_q   <= bsq_pkg::K_INTOP;
      addr_q   <= bsq_pkg::RESTART_ADDR;
      wdata_q  <= 8'h00;
      io_int_q <= 1'b0;
    end else begin
      st_q     <= st_n;
      kind_q   <= kind_n;
      addr_q   <= addr_n;
      wdata_q  <= wdata_n;
      io_int_q <= io_int_n;
    end
  end

  // Wait generator, loaded when a cycle starts
  assign gen_dec = tick && wait_smp_q &&
                   ((st_q == bsq_pkg::ST_T2) || (st_q == bsq_pkg::ST_TW));
  bsq_wait_gen u_wait_gen (
    .clk         (SYS_CLK),
    .rst         (RST),
    .load        (accept || rst_exit || pin_rst),
    .kind        (kind_n),
    .io_internal (io_int_n),
    .io_field    (wait_ctl_q[bsq_pkg::IO_FLD_LO +: 2]),
    .mem_field   (wait_ctl_q[bsq_pkg::MEM_FLD_LO +: 2]),
    .dec         (gen_dec),
    .pending     (gen_pend)
  );

  // Wait control register; pin reset forces both fields to ones
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wait_ctl_q <= bsq_pkg::WAIT_CTL_RST;
    end else if (pin_rst) begin
      wait_ctl_q <= bsq_pkg::WAIT_CTL_RST;
    end else if (REG_WR && REG_ADDR == bsq_pkg::REG_WAIT_CTL) begin
      wait_ctl_q <= REG_WDATA;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      reg_rdata_q <= 8'h00;
    end else if (!REG_RD) begin
      reg_rdata_q <= 8'h00;
    end else begin
      case (REG_ADDR)
        bsq_pkg::REG_WAIT_CTL: reg_rdata_q <= wait_ctl_q;
        bsq_pkg::REG_STATUS: begin
          reg_rdata_q <= {bsq_pkg::STATUS_PAD, gen_pend, pin_rst,
                          st_q == bsq_pkg::ST_TX, st_q};
        end
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // Pin levels follow the state being entered, so they leave flops aligned
  assign act      = (st_n == bsq_pkg::ST_T1) || (st_n == bsq_pkg::ST_T2) ||
                    (st_n == bsq_pkg::ST_TW) || (st_n == bsq_pkg::ST_T3);
  assign late     = (st_n == bsq_pkg::ST_T2) || (st_n == bsq_pkg::ST_TW) ||
                    (st_n == bsq_pkg::ST_T3 && !ph_n);
  assign mem_kind = (kind_n == bsq_pkg::K_FETCH) || (kind_n == bsq_pkg::K_MRD) ||
                    (kind_n == bsq_pkg::K_MWR);
  assign rd_kind  = act && !bsq_pkg::is_wr(kind_n);
  // Strobes start in the low half of T1; writes drop them early in T3
  assign strb     = (st_n == bsq_pkg::ST_T1 && ph_n) || late ||
                    (st_n == bsq_pkg::ST_T3 && !bsq_pkg::is_wr(kind_n));

  // Fetch latches entering T3, other reads at the T3 falling edge
  assign capture  = ((kind_q == bsq_pkg::K_FETCH) && st_q != bsq_pkg::ST_T3 &&
                     st_n == bsq_pkg::ST_T3) ||
                    (rd_kind && kind_q != bsq_pkg::K_FETCH &&
                     st_q == bsq_pkg::ST_T3 && !ph_q);

  // Pin and answer registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      addr_out_q  <= bsq_pkg::RESTART_ADDR;
      addr_oe_q   <= 1'b0;
      data_out_q  <= 8'h00;
      data_oe_q   <= 1'b0;
      memory_request_n_n_q    <= 1'b1;
      io_request_n_n_q    <= 1'b1;
      rd_n_q      <= 1'b1;
      wr_n_q      <= 1'b1;
      ctl_oe_q    <= 1'b0;
      m1_n_q      <= 1'b1;
      grant_n_q   <= 1'b1;
      refr_hold_q <= 1'b0;
    end else begin
      addr_out_q  <= addr_n;
      addr_oe_q   <= st_n != bsq_pkg::ST_TX;
      data_out_q  <= wdata_n;
      data_oe_q   <= bsq_pkg::is_wr(kind_n) && act && late;
      memory_request_n_n_q    <= !(strb && act && mem_kind);
      io_request_n_n_q    <= !(strb && act && bsq_pkg::is_io(kind_n));
      rd_n_q      <= !(strb && rd_kind);
      wr_n_q      <= !(late && act && bsq_pkg::is_wr(kind_n));
      ctl_oe_q    <= st_n != bsq_pkg::ST_TX;
      m1_n_q      <= !(act && kind_n == bsq_pkg::K_FETCH);
      grant_n_q   <= st_n != bsq_pkg::ST_TX;
      // Refresh logic elsewhere must not run while waiting or released
      refr_hold_q <= st_n == bsq_pkg::ST_TW || st_n == bsq_pkg::ST_TX;
    end
  end

  // Answer to the core, pulsed as the cycle leaves T3
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rsp_data_q  <= 8'h00;
      rsp_valid_q <= 1'b0;
      restart_q   <= 1'b0;
    end else begin
      if (capture) begin
        rsp_data_q <= data_s;
      end
      rsp_valid_q <= tick && st_q == bsq_pkg::ST_T3 && !pin_rst;
      restart_q   <= rst_exit;
    end
  end

  // Port drivers
  assign BUS_CLK               = bclk_q;
  assign REG_RDATA             = reg_rdata_q;
  assign RSP_VALID             = rsp_valid_q;
  assign RSP_DATA              = rsp_data_q;
  assign RESTART               = restart_q;
  assign ADDR_OUT              = addr_out_q;
  assign ADDR_OE               = addr_oe_q;
  assign DATA_OUT              = data_out_q;
  assign DATA_OE               = data_oe_q;
  assign MEMORY_REQUEST_N      = memory_request_n_n_q;
  assign IO_REQUEST_N          = io_request_n_n_q;
  assign READ_STROBE_N         = rd_n_q;
  assign WRITE_STROBE_N        = wr_n_q;
  assign CTL_OE                = ctl_oe_q;
  assign OPCODE_FETCH_STROBE_N = m1_n_q;
  assign BUS_GRANT_N           = grant_n_q;
  assign REFRESH_HOLD          = refr_hold_q;

  // Checks on the sequencer
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  sequence s_wr_t2;
    bsq_pkg::is_wr(kind_q) && $rose(st_q == bsq_pkg::ST_T2);
  endsequence

  sequence s_io_t2_end;
    st_q == bsq_pkg::ST_T2 && ph_q && bsq_pkg::is_io(kind_q) && !io_int_q && !pin_rst;
  endsequence

  chk_t1_then_t2: assert property (
    st_q == bsq_pkg::ST_T1 && ph_q && !pin_rst |=> st_q == bsq_pkg::ST_T2)
    else $error("T1 not followed by T2");
  chk_intop_single: assert property (
    st_q == bsq_pkg::ST_TI && ph_q && !pin_rst |=>
    st_q inside {bsq_pkg::ST_T1, bsq_pkg::ST_TI, bsq_pkg::ST_TX})
    else $error("Internal cycle longer than one state");
  chk_half_toggle: assert property (
    1'b1 |=> ph_q != $past(ph_q))
    else $error("Bus clock phase did not toggle");
  chk_wait_after_t2: assert property (
    $rose(st_q == bsq_pkg::ST_TW) |-> $past(st_q) == bsq_pkg::ST_T2)
    else $error("Wait state not entered from T2");
  chk_fetch_strobe: assert property (
    st_q == bsq_pkg::ST_T2 && kind_q == bsq_pkg::K_FETCH |-> !OPCODE_FETCH_STROBE_N)
    else $error("Fetch strobe high in fetch T2");
  chk_fetch_enable: assert property (
    st_q == bsq_pkg::ST_T1 && ph_q && kind_q == bsq_pkg::K_FETCH |->
    !MEMORY_REQUEST_N && !READ_STROBE_N)
    else $error("Fetch strobes late in T1");
  chk_wait_stable: assert property (
    st_q == bsq_pkg::ST_TW && $past(st_q) == bsq_pkg::ST_TW |->
    $stable(ADDR_OUT) && $stable(MEMORY_REQUEST_N) && $stable(READ_STROBE_N) &&
    $stable(OPCODE_FETCH_STROBE_N))
    else $error("Bus changed during wait state");
  chk_write_seq: assert property (
    s_wr_t2 |-> !WRITE_STROBE_N && DATA_OE ##1 !WRITE_STROBE_N)
    else $error("Write strobe missing in T2");
  chk_io_upper: assert property (
    !IO_REQUEST_N |-> ADDR_OUT[19:16] == bsq_pkg::IO_HI_ZERO)
    else $error("Upper address high in I/O cycle");
  chk_io_forced_wait: assert property (
    s_io_t2_end |=> st_q == bsq_pkg::ST_TW)
    else $error("External I/O cycle without wait");
  chk_reset_abort: assert property (
    pin_rst |=> st_q == bsq_pkg::ST_RST && MEMORY_REQUEST_N && IO_REQUEST_N)
    else $error("Reset did not abort cycle");
  chk_release_float: assert property (
    !BUS_GRANT_N |-> !ADDR_OE && !CTL_OE && !DATA_OE)
    else $error("Bus driven while granted away");

endmodule

/* test/bsq_bus_model.sv */
// Purpose: Far side of the sequencer: slow memory and I/O device.
// Assumes: Bench sets hold, the cycles WAIT_N stays low per access.
// Notes:   Unselected data lines toggle so stale bytes never match.
`timescale 1ns/1ps
module bsq_bus_model (
  // Clock
  input  wire logic        clk,
  // Bus pins from the sequencer
  input  wire logic [19:0] addr,
  input  wire logic        ctl_oe,
  input  wire logic        memory_request_n_n,
  input  wire logic        ioreq_n,
  input  wire logic        rd_n,
  // Bench control
  input  wire logic [3:0]  hold,
  // Pins back to the sequencer
  output logic [7:0]       data_in,
  output logic             wait_n
);
  logic [3:0] age_q = 4'h0;
  wire        sel   = ctl_oe && !(memory_request_n_n && ioreq_n);
  initial data_in = 8'h00;
  // Access age and read data; released bus shows the inverse of the last byte
  always @(posedge clk) begin
    age_q <= sel ? ((age_q == 4'hf) ? age_q : age_q + 4'h1) : 4'h0;
    data_in <= (sel && !rd_n) ? (addr[7:0] ^ 8'h5a) : ~data_in;
  end
  // Slow device stretches the access through the wait pin
  assign wait_n = !(sel && (age_q < hold));
endmodule

/* test/bsq_top_bench.sv */
// Purpose: Self-checking bench of the bus cycle sequencer.
// Assumes: Bench plays the core and the alternate master.
// Notes:   Waits are judged from the length of accept to response.
`timescale 1ns/1ps
module bsq_top_bench;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
  logic reset_n = 1'b1, bus_request_n_n = 1'b1, io_seen, m1_seen, hi_seen;
  logic [3:0] reg_addr = 4'h0, hold = 4'h0;
  logic [7:0] reg_wdata = 8'h00, rdata, din, rsp_data, dout, wd;
  logic [19:0] req_addr = 20'h00000, addr_out;
  bsq_pkg::bsq_kind_t req_kind = bsq_pkg::K_MRD;
  logic ready, rsp_v, restart, aoe, doe, memory_request_n_n, ioreq_n, rd_n, wr_n, ctl_oe, m1_n;
  logic wait_n, grant_n, bclk, rfh, io_int = 1'b0;
  int error_cnt = 0, checks_done = 0, n;
  // Clock, 100 ns period
  always #50 clk = ~clk;
  bsq_top dut (.SYS_CLK(clk), .RST(rst), .BUS_CLK(bclk), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
    .REQ_VALID(req_valid), .REQ_KIND(req_kind), .REQ_ADDR(req_addr),
    .REQ_WDATA(8'h3c), .REQ_IO_INTERNAL(io_int), .REQ_READY(ready), .RSP_VALID(rsp_v),
    .RSP_DATA(rsp_data), .RESTART(restart), .ADDR_OUT(addr_out), .ADDR_OE(aoe),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .MEMORY_REQUEST_N(memory_request_n_n),
    .IO_REQUEST_N(ioreq_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
    .CTL_OE(ctl_oe), .OPCODE_FETCH_STROBE_N(m1_n), .WAIT_N(wait_n),
    .RESET_N(reset_n), .BUS_REQUEST_N(bus_request_n_n), .BUS_GRANT_N(grant_n),
    .REFRESH_HOLD(rfh));
  bsq_bus_model mdl (.clk(clk), .addr(addr_out), .ctl_oe(ctl_oe), .memory_request_n_n(memory_request_n_n),
    .ioreq_n(ioreq_n), .rd_n(rd_n), .hold(hold), .data_in(din), .wait_n(wait_n));
  // Verdict in one place
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // Register port: one-cycle strobes, read data the cycle after
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg read", {12'h000, e}, {12'h000, rdata});
  endtask
  // Bounded wait on a pin level; a timeout ends the run
  task automatic wait_pin(ref logic s, input logic v);
    int i;
    for (i = 0; i < 400 && s !== v; i++) @(negedge clk);
    if (s !== v) begin
      error_cnt++;
      end_sim();
    end
  endtask
  // One machine cycle: n counts clocks from accept to response
  task automatic run_cyc(input bsq_pkg::bsq_kind_t k, input logic [19:0] a);
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= a;
    @(negedge clk);
    wait_pin(ready, 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    {n, io_seen, m1_seen, hi_seen} = '0;
    wd = 8'h00;
    do begin
      @(posedge clk);
      #1 n++;
      io_seen |= !ioreq_n;
      m1_seen |= !m1_n;
      hi_seen |= !ioreq_n && addr_out[19:16] != 4'h0;
      if (!wr_n && doe) wd = dout;
    end while (!rsp_v && n < 400);
    // A cycle that never answers ends the run
    if (!rsp_v) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic t_reset;
    @(posedge clk);
    #1 hi_seen = bclk;
    @(posedge clk);
    #1 chk("bus clock", 20'(!hi_seen), 20'(bclk));
    rd_reg(4'h0, 8'hf0);
    rd_reg(4'hf, 8'h00);
    $display("done reset values");
  endtask
  task automatic t_mem;
    for (int w = 0; w < 4; w++) begin
      wr_reg(4'h0, {w[1:0], 6'h00});
      run_cyc(bsq_pkg::K_MRD, 20'hab010 + 20'(w));
      chk("mem read len", 20'(6 + 2 * w), 20'(n));
      chk("mem read data", 20'(8'h4a ^ w[7:0]), 20'(rsp_data));
      chk("mem read m1", 20'h0, 20'(m1_seen));
    end
    run_cyc(bsq_pkg::K_MWR, 20'h00100);
    chk("mem write len", 20'(12), 20'(n));
    chk("mem write data", 20'h3c, 20'(wd));
    run_cyc(bsq_pkg::K_FETCH, 20'h00200);
    chk("fetch m1", 20'h1, 20'(m1_seen));
    // Internal operation: one state, so the next boundary follows at once
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= bsq_pkg::K_INTOP;
    @(negedge clk);
    wait_pin(ready, 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    chk("intop len", 20'h1, 20'(ready));
    $display("done memory cycles");
  endtask
  task automatic t_io;
    for (int f = 0; f < 4; f++) begin
      wr_reg(4'h0, {2'b00, f[1:0], 4'h0});
      run_cyc(f[0] ? bsq_pkg::K_IOWR : bsq_pkg::K_IORD, 20'hf1234);
      chk("io len", 20'(8 + 2 * f), 20'(n));
      chk("io strobe", 20'h1, 20'(io_seen));
      chk("io upper addr", 20'h0, 20'(hi_seen));
    end
    @(posedge clk);
    io_int <= 1'b1;
    run_cyc(bsq_pkg::K_IORD, 20'h00012);
    chk("internal io len", 20'(6), 20'(n));
    @(posedge clk);
    io_int <= 1'b0;
    $display("done io cycles");
  endtask
  task automatic t_wait;
    // Pin is seen two clocks late: four low clocks from T1 give three waits
    wr_reg(4'h0, 8'h40);
    hold <= 4'h4;
    run_cyc(bsq_pkg::K_MRD, 20'h00300);
    chk("pin wait", 20'h1, 20'(n > 8));
    wr_reg(4'h0, 8'h80);
    run_cyc(bsq_pkg::K_MRD, 20'h00300);
    chk("max wait", 20'(12), 20'(n));
    hold <= 4'h0;
    $display("done wait pin");
  endtask
  task automatic t_bus;
    @(posedge clk);
    bus_request_n_n <= 1'b0;
    wait_pin(grant_n, 1'b0);
    repeat (10) @(posedge clk);
    #1 chk("held grant", 20'h0, 20'(grant_n));
    chk("float", 20'h0, 20'({aoe, ctl_oe, doe}));
    chk("refresh hold", 20'h1, 20'(rfh));
    @(posedge clk);
    bus_request_n_n <= 1'b1;
    wait_pin(grant_n, 1'b1);
    $display("done bus exchange");
  endtask
  task automatic t_pinrst;
    wr_reg(4'h0, 8'h00);
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    wait_pin(restart, 1'b1);
    @(posedge clk);
    #1 chk("restart addr", 20'h00000, addr_out);
    rd_reg(4'h0, 8'hf0);
    $display("done pin reset");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mem();
    t_io();
    t_wait();
    t_bus();
    t_pinrst();
    end_sim();
  end
endmodule
